// ### hw/ppd_pkg.sv
package ppd_pkg;
    // Entry layout
    localparam int ENTRY_W = 512;
    localparam int RSVD_HI_LSB = 336;
    localparam int RSVD_HI_W = ENTRY_W - RSVD_HI_LSB;
    localparam int TAG_LSB = 320;
    localparam int TAG_W = 16;
    localparam int SEG_LSB = 256;
    localparam int SEG_W = 64;
    localparam int SEG_RSVD_LSB = 3;
    localparam int SEG_RSVD_W = 9;
    localparam int PFD_BIT = 2;
    localparam int SIZE_LSB = 0;
    localparam int SIZE_W = 2;
    localparam int ROOT_LSB = 12;
    localparam int ROOT_W = 40;
    localparam int ROOT_ENTRY_LSB = SEG_LSB + ROOT_LSB;
    localparam int MAX_HOST_AW = 52;
    localparam int ADDR_W = 64;
    localparam int BASE_ADDR_BITS = 49;
    localparam int WIDTH_W = 7;

    // APB map
    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TAG = 12'h008;
    localparam logic [11:0] OFS_ROOT_LO = 12'h00c;
    localparam logic [11:0] OFS_ROOT_HI = 12'h010;

    // Config fields and reset values
    localparam int CFG_HOST_AW_LSB = 0;
    localparam int CFG_HOST_AW_W = 6;
    localparam int CFG_TAGW_LSB = 8;
    localparam int CFG_TAGW_W = 5;
    localparam logic [5:0] HOST_AW_RESET = 6'h34;
    localparam logic [4:0] TAGW_RESET = 5'h10;

    // Status fields
    localparam int ST_FAULT = 0;
    localparam int ST_DENY = 1;
    localparam int ST_ACTIVE = 2;
    localparam int ST_PFD = 3;
    localparam int ST_SIZE_LSB = 4;
endpackage

// ### hw/ppd_check.sv
`timescale 1ns/1ps
module ppd_check (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Translated request
    input wire logic i_req_valid,
    input wire logic [ppd_pkg::ADDR_W-1:0] i_addr,
    // Decoded entry state
    input wire logic [ppd_pkg::SIZE_W-1:0] i_size,
    input wire logic i_active,
    input wire logic i_fault,
    // Verdict
    output logic o_done,
    output logic o_allowed
);
    logic [ppd_pkg::WIDTH_W-1:0] limit_bits;
    logic over;

    // Each size code adds one address bit above the base
    assign limit_bits = ppd_pkg::WIDTH_W'(ppd_pkg::BASE_ADDR_BITS) + ppd_pkg::WIDTH_W'(i_size);
    assign over = |(i_addr >> limit_bits);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
            o_allowed <= 1'b0;
        end else begin
            o_done <= i_req_valid;
            // A faulty entry blocks everything; no bound applies when permissions are off
            o_allowed <= i_req_valid & ~i_fault & ~(i_active & over);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_bound_deny: assert property (
        i_req_valid && i_active && !i_fault &&
        (i_addr >= (64'h1 << (ppd_pkg::BASE_ADDR_BITS + i_size)))
        |=> o_done && !o_allowed)
        else $error("request above size limit was allowed");
    chk_bound_allow: assert property (
        i_req_valid && i_active && !i_fault &&
        (i_addr < (64'h1 << (ppd_pkg::BASE_ADDR_BITS + i_size)))
        |=> o_done && o_allowed)
        else $error("request within size limit was denied");
    cov_deny: cover property (i_req_valid && i_active ##1 !o_allowed);
endmodule

// ### hw/ppd_decode.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - With permission tables unsupported, every permission field is reserved and must be zero.
// - The domain tag is taken from entry bits 335:320.
// - Cache entries derived from the entry are labelled with the domain tag.
// - Tag bits above the configured tag width are reserved.
// - The table root is taken from bits host_addr_width+255:268.
// - With the context permission enable clear, tag, root, prefetch and size are ignored.
// - Bit 258 set forbids prefetching after a serviced translation; clear permits it.
// - Bits 257:256 give the table size code, 4KB through 32KB.
module ppd_decode (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Capability and context
    input wire logic i_perm_tables_supported,
    input wire logic i_ctx_perm_enable,
    // Entry from memory
    input wire logic i_entry_valid,
    input wire logic [ppd_pkg::ENTRY_W-1:0] i_entry,
    // Decoded fields
    output logic o_dec_valid,
    output logic o_perm_active,
    output logic o_entry_fault,
    output logic [ppd_pkg::TAG_W-1:0] o_perm_domain_tag,
    output logic [ppd_pkg::ROOT_W-1:0] o_perm_table_root,
    output logic o_perm_prefetch_inhibit,
    output logic [ppd_pkg::SIZE_W-1:0] o_perm_table_size,
    // Translated request check
    input wire logic i_xlat_valid,
    input wire logic [ppd_pkg::ADDR_W-1:0] i_xlat_addr,
    output logic o_xlat_done,
    output logic o_xlat_allowed,
    // Prefetch after a serviced translation
    input wire logic i_xlat_serviced,
    output logic o_prefetch_req
);
    function automatic logic [63:0] low_mask(input logic [ppd_pkg::WIDTH_W-1:0] n);
        low_mask = (n >= 7'h40) ? 64'hffffffffffffffff : ((64'h1 << n) - 64'h1);
    endfunction

    logic rst_meta;
    logic rst_n;
    logic [ppd_pkg::CFG_HOST_AW_W-1:0] cfg_host_aw;
    logic [ppd_pkg::CFG_TAGW_W-1:0] cfg_tagw;
    logic fault_sticky;
    logic deny_sticky;
    logic [31:0] next_prdata;
    logic next_slverr;
    logic wr_en;
    logic [ppd_pkg::SEG_W-1:0] seg;
    logic [63:0] host_aw_mask;
    logic [63:0] tag_mask;
    logic [63:0] root_full;
    logic [ppd_pkg::TAG_W-1:0] raw_tag;
    logic [ppd_pkg::TAG_W-1:0] tag_mask16;
    logic [ppd_pkg::ROOT_W-1:0] root_dec;
    logic [ppd_pkg::ROOT_W-1:0] root_raw;
    logic [ppd_pkg::SIZE_W-1:0] raw_size;
    logic rsvd_top;
    logic rsvd_mid;
    logic rsvd_low;
    logic rsvd_tag;
    logic perm_fields_nz;
    logic fault_in;
    logic active_in;

    // Reset release through two flops
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Field extraction
    assign seg = i_entry[ppd_pkg::SEG_LSB +: ppd_pkg::SEG_W];
    assign host_aw_mask = low_mask(ppd_pkg::WIDTH_W'(cfg_host_aw));
    assign tag_mask = low_mask(ppd_pkg::WIDTH_W'(cfg_tagw));
    assign tag_mask16 = tag_mask[ppd_pkg::TAG_W-1:0];
    assign raw_tag = i_entry[ppd_pkg::TAG_LSB +: ppd_pkg::TAG_W];
    assign root_full = (seg & host_aw_mask) >> ppd_pkg::ROOT_LSB;
    assign root_dec = root_full[ppd_pkg::ROOT_W-1:0];
    assign root_raw = i_entry[ppd_pkg::ROOT_ENTRY_LSB +: ppd_pkg::ROOT_W];
    assign raw_size = seg[ppd_pkg::SIZE_LSB +: ppd_pkg::SIZE_W];

    // Reserved checks; hardware flags what software should have kept clear
    assign rsvd_top = |i_entry[ppd_pkg::RSVD_HI_LSB +: ppd_pkg::RSVD_HI_W];
    assign rsvd_mid = |(seg & ~host_aw_mask);
    assign rsvd_low = |seg[ppd_pkg::SEG_RSVD_LSB +: ppd_pkg::SEG_RSVD_W];
    assign rsvd_tag = |(raw_tag & ~tag_mask16);
    assign perm_fields_nz = (|raw_tag) | (|seg);
    assign fault_in = rsvd_top | rsvd_mid | rsvd_low |
        (i_perm_tables_supported ? rsvd_tag : perm_fields_nz);
    assign active_in = i_perm_tables_supported & i_ctx_perm_enable;

    // Decode stage; fields stay until the next entry arrives
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_dec_valid <= 1'b0;
            o_perm_active <= 1'b0;
            o_entry_fault <= 1'b0;
            o_perm_domain_tag <= '0;
            o_perm_table_root <= '0;
            o_perm_prefetch_inhibit <= 1'b0;
            o_perm_table_size <= '0;
        end else begin
            o_dec_valid <= i_entry_valid;
            if (i_entry_valid) begin
                o_perm_active <= active_in;
                o_entry_fault <= fault_in;
                if (active_in) begin
                    o_perm_domain_tag <= raw_tag & tag_mask16;
                    o_perm_table_root <= root_dec;
                    o_perm_prefetch_inhibit <= seg[ppd_pkg::PFD_BIT];
                    o_perm_table_size <= raw_size;
                end else begin
                    o_perm_domain_tag <= '0;
                    o_perm_table_root <= '0;
                    o_perm_prefetch_inhibit <= 1'b0;
                    o_perm_table_size <= '0;
                end
            end
        end
    end

    // Prefetch only for a clean, active entry with prefetch not inhibited
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_prefetch_req <= 1'b0;
        end else begin
            o_prefetch_req <= i_xlat_serviced & ~i_entry_valid & o_perm_active &
                ~o_entry_fault & ~o_perm_prefetch_inhibit;
        end
    end

    ppd_check u_check (
        .i_clk(i_mclk),
        .i_rst_n(rst_n),
        .i_req_valid(i_xlat_valid),
        .i_addr(i_xlat_addr),
        .i_size(o_perm_table_size),
        .i_active(o_perm_active),
        .i_fault(o_entry_fault),
        .o_done(o_xlat_done),
        .o_allowed(o_xlat_allowed)
    );

    // APB: zero wait states, ready is raised in the access cycle
    assign wr_en = i_psel & i_penable & i_pwrite & o_pready;

    always_comb begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        case (i_paddr)
            ppd_pkg::OFS_CFG: begin
                next_prdata[ppd_pkg::CFG_HOST_AW_LSB +: ppd_pkg::CFG_HOST_AW_W] = cfg_host_aw;
                next_prdata[ppd_pkg::CFG_TAGW_LSB +: ppd_pkg::CFG_TAGW_W] = cfg_tagw;
            end
            ppd_pkg::OFS_STATUS: begin
                next_prdata[ppd_pkg::ST_FAULT] = fault_sticky;
                next_prdata[ppd_pkg::ST_DENY] = deny_sticky;
                next_prdata[ppd_pkg::ST_ACTIVE] = o_perm_active;
                next_prdata[ppd_pkg::ST_PFD] = o_perm_prefetch_inhibit;
                next_prdata[ppd_pkg::ST_SIZE_LSB +: ppd_pkg::SIZE_W] = o_perm_table_size;
            end
            ppd_pkg::OFS_TAG: next_prdata[ppd_pkg::TAG_W-1:0] = o_perm_domain_tag;
            ppd_pkg::OFS_ROOT_LO: next_prdata = o_perm_table_root[31:0];
            ppd_pkg::OFS_ROOT_HI: next_prdata[ppd_pkg::ROOT_W-33:0] =
                o_perm_table_root[ppd_pkg::ROOT_W-1:32];
            default: next_slverr = 1'b1;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & next_slverr;
            o_prdata <= (i_psel & ~i_penable & ~i_pwrite) ? next_prdata : 32'h00000000;
        end
    end

    // Widths beyond what the decoder can hold are clamped, not wrapped
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_host_aw <= ppd_pkg::HOST_AW_RESET;
            cfg_tagw <= ppd_pkg::TAGW_RESET;
        end else if (wr_en && i_paddr == ppd_pkg::OFS_CFG) begin
            cfg_host_aw <= (i_pwdata[ppd_pkg::CFG_HOST_AW_LSB +: ppd_pkg::CFG_HOST_AW_W] >
                ppd_pkg::HOST_AW_RESET) ? ppd_pkg::HOST_AW_RESET :
                i_pwdata[ppd_pkg::CFG_HOST_AW_LSB +: ppd_pkg::CFG_HOST_AW_W];
            cfg_tagw <= (i_pwdata[ppd_pkg::CFG_TAGW_LSB +: ppd_pkg::CFG_TAGW_W] >
                ppd_pkg::TAGW_RESET) ? ppd_pkg::TAGW_RESET :
                i_pwdata[ppd_pkg::CFG_TAGW_LSB +: ppd_pkg::CFG_TAGW_W];
        end
    end

    // Sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_sticky <= 1'b0;
            deny_sticky <= 1'b0;
        end else begin
            fault_sticky <= (i_entry_valid & fault_in) | (fault_sticky &
                ~(wr_en & (i_paddr == ppd_pkg::OFS_STATUS) & i_pwdata[ppd_pkg::ST_FAULT]));
            deny_sticky <= (o_xlat_done & ~o_xlat_allowed) | (deny_sticky &
                ~(wr_en & (i_paddr == ppd_pkg::OFS_STATUS) & i_pwdata[ppd_pkg::ST_DENY]));
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    chk_unsupported_rsvd: assert property (
        i_entry_valid && !i_perm_tables_supported && perm_fields_nz
        |=> o_entry_fault && !o_perm_active)
        else $error("permission fields not reserved when unsupported");
    chk_tag_decode: assert property (
        i_entry_valid && active_in && cfg_tagw == ppd_pkg::TAGW_RESET
        |=> o_perm_domain_tag == $past(raw_tag))
        else $error("domain tag not taken from its field");
    chk_tag_label: assert property (
        o_dec_valid ##1 !i_entry_valid [*2] |=> $stable(o_perm_domain_tag))
        else $error("cache label changed without a new entry");
    chk_tag_width: assert property (
        i_entry_valid && i_perm_tables_supported && rsvd_tag
        |=> o_entry_fault && ((o_perm_domain_tag & ~$past(tag_mask16)) == 16'h0000))
        else $error("unused tag bits not treated as reserved");
    chk_root_decode: assert property (
        i_entry_valid && active_in && cfg_host_aw == ppd_pkg::HOST_AW_RESET
        |=> o_perm_table_root == $past(root_raw))
        else $error("table root not taken from its field");
    chk_disregard: assert property (
        i_entry_valid && !i_ctx_perm_enable |=> !o_perm_active && o_perm_domain_tag == 16'h0000
        && o_perm_table_root == 40'h0000000000 && !o_perm_prefetch_inhibit
        && o_perm_table_size == 2'h0)
        else $error("fields used while permission enable clear");
    chk_prefetch_gate: assert property (
        o_prefetch_req |-> !o_perm_prefetch_inhibit && o_perm_active && $past(i_xlat_serviced))
        else $error("prefetch issued while inhibited");
    chk_size_decode: assert property (
        i_entry_valid && active_in |=> o_perm_table_size == $past(raw_size))
        else $error("table size code not taken from its field");
    chk_deny_sticky: assert property (
        o_xlat_done && !o_xlat_allowed |=> deny_sticky)
        else $error("denied request not recorded");

    cov_active_entry: cover property (i_entry_valid && active_in && !fault_in ##1 o_dec_valid);
    cov_prefetch: cover property (i_xlat_serviced ##1 o_prefetch_req);
    cov_fault: cover property (i_entry_valid && fault_in ##1 fault_sticky);
endmodule

// ### testbench/ppd_entry_mem.sv
`timescale 1ns/1ps
module ppd_entry_mem (
    // Clock
    input wire logic i_mclk,
    // Fetch request
    input wire logic i_fetch,
    input wire logic [1:0] i_idx,
    input wire logic i_slow,
    // Entry towards the decoder
    output logic o_entry_valid,
    output logic [511:0] o_entry
);
    logic [511:0] mem [4];
    logic [1:0] idx = '0;
    int cnt = 0;

    initial begin
        o_entry_valid = 1'b0;
        o_entry = '0;
    end

    // Junk is only for scenarios that break the layout on purpose
    task automatic store(input int k, input logic [15:0] tag, input logic [39:0] root,
            input logic pfd, input logic [1:0] sz, input logic [511:0] junk);
        logic [511:0] e;
        e = '0;
        for (int j = 0; j < 4; j++) begin
            if (j != k && mem[j][335:320] === tag) begin
                root = mem[j][307:268];
            end
        end
        e[335:320] = tag;
        e[307:268] = root;
        e[258] = pfd;
        e[257:256] = sz;
        mem[k] = e | junk;
    endtask

    // Between fetches the bus toggles so no stale entry looks valid
    always @(posedge i_mclk) begin
        o_entry_valid <= 1'b0;
        o_entry <= ~o_entry;
        if (i_fetch) begin
            idx <= i_idx;
            cnt <= i_slow ? 4 : 1;
        end else if (cnt == 1) begin
            o_entry_valid <= 1'b1;
            o_entry <= mem[idx];
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### testbench/tb_ppd_decode.sv
`timescale 1ns/1ps
module tb_ppd_decode;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sup = 1, ctx = 1;
    logic xv = 0, sv = 0, fetch = 0, slow = 0, err;
    logic pready, pslverr, ev, dv, act, flt, pfd, xd, xa, pf;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0] fidx = '0, sz;
    logic [511:0] ent;
    logic [15:0] tag;
    logic [39:0] root;
    logic [63:0] xaddr = '0;
    int n_errors = 0, checked = 0;

    initial begin
        forever #20 clk = ~clk;
    end

    ppd_entry_mem ppd_entry_mem_i (.i_mclk(clk), .i_fetch(fetch), .i_idx(fidx),
        .i_slow(slow), .o_entry_valid(ev), .o_entry(ent));
    ppd_decode ppd_decode_i (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_perm_tables_supported(sup), .i_ctx_perm_enable(ctx), .i_entry_valid(ev),
        .i_entry(ent), .o_dec_valid(dv), .o_perm_active(act), .o_entry_fault(flt),
        .o_perm_domain_tag(tag), .o_perm_table_root(root), .o_perm_prefetch_inhibit(pfd),
        .o_perm_table_size(sz), .i_xlat_valid(xv), .i_xlat_addr(xaddr), .o_xlat_done(xd),
        .o_xlat_allowed(xa), .i_xlat_serviced(sv), .o_prefetch_req(pf));

    task automatic summarize();
        $display("Comparisons: %0d, mismatches: %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic timeout();
        chk(1'b0, "no answer in time");
        summarize();
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready, data and error are taken at the rising edge that samples ready high
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic load(input logic [1:0] k, input logic s);
        int n;
        n = 0;
        @(posedge clk);
        fetch <= 1'b1;
        fidx <= k;
        slow <= s;
        @(posedge clk);
        fetch <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (dv !== 1'b1 && n < 20);
        if (dv !== 1'b1) timeout();
    endtask

    task automatic fields(input logic [15:0] t, input logic [39:0] r, input logic p,
            input logic [1:0] s, input logic a);
        chk(tag === t && act === a && flt === 1'b0, "domain tag");
        chk(root === r, "table root");
        chk(pfd === p && sz === s, "prefetch inhibit or size");
    endtask

    task automatic xlat(input logic [63:0] a, input logic ok);
        @(posedge clk);
        xv <= 1'b1;
        xaddr <= a;
        @(posedge clk);
        xv <= 1'b0;
        @(negedge clk);
        chk(xd === 1'b1 && xa === ok, "translated request verdict");
    endtask

    task automatic svc(input logic exp);
        @(posedge clk);
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        @(negedge clk);
        chk(pf === exp, "prefetch request");
    endtask

    task automatic t_regs();
        apb(1'b0, ppd_pkg::OFS_CFG, '0);
        chk(rd === 32'h0000_1034 && err === 1'b0, "config reset value");
        apb(1'b0, 12'h040, '0);
        chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped address");
        apb(1'b1, ppd_pkg::OFS_CFG, 32'h0000_103f);
        apb(1'b0, ppd_pkg::OFS_CFG, '0);
        chk(rd === 32'h0000_1034, "host width clamp");
    endtask

    task automatic t_fields();
        ppd_entry_mem_i.store(0, 16'hbeef, 40'h12_3456_789a, 1'b1, 2'h2, '0);
        load(2'h0, 1'b1);
        fields(16'hbeef, 40'h12_3456_789a, 1'b1, 2'h2, 1'b1);
        apb(1'b0, ppd_pkg::OFS_TAG, '0);
        chk(rd === 32'h0000_beef, "tag register");
        apb(1'b0, ppd_pkg::OFS_ROOT_LO, '0);
        chk(rd === 32'h3456_789a, "root low word");
        apb(1'b0, ppd_pkg::OFS_ROOT_HI, '0);
        chk(rd === 32'h0000_0012, "root high bits");
        apb(1'b0, ppd_pkg::OFS_STATUS, '0);
        chk(rd[5:2] === 4'b1011, "status fields");
        svc(1'b0);
    endtask

    task automatic t_size();
        for (int s = 0; s < 4; s++) begin
            ppd_entry_mem_i.store(1, 16'h0100 + 16'(s), 40'h1000, 1'b0, 2'(s), '0);
            load(2'h1, 1'(s));
            fields(16'h0100 + 16'(s), 40'h1000, 1'b0, 2'(s), 1'b1);
            xlat((64'h1 << (49 + s)) - 64'h1, 1'b1);
            xlat(64'h1 << (49 + s), 1'b0);
            svc(1'b1);
        end
    endtask

    task automatic t_ctx_sup();
        @(posedge clk);
        ctx <= 1'b0;
        load(2'h0, 1'b0);
        fields('0, '0, 1'b0, 2'h0, 1'b0);
        xlat(64'hffff_ffff_ffff_ffff, 1'b1);
        @(posedge clk);
        ctx <= 1'b1;
        sup <= 1'b0;
        load(2'h0, 1'b0);
        chk(flt === 1'b1, "fields set while unsupported");
        xlat(64'h0, 1'b0);
        ppd_entry_mem_i.store(2, '0, '0, 1'b0, 2'h0, '0);
        load(2'h2, 1'b0);
        chk(flt === 1'b0, "clean entry while unsupported");
        @(posedge clk);
        sup <= 1'b1;
    endtask

    task automatic t_tagw();
        apb(1'b1, ppd_pkg::OFS_CFG, 32'h0000_0834);
        ppd_entry_mem_i.store(3, 16'h00ab, 40'h2, 1'b0, 2'h0, '0);
        load(2'h3, 1'b0);
        chk(tag === 16'h00ab && flt === 1'b0, "narrow tag in range");
        ppd_entry_mem_i.store(3, 16'h01ab, 40'h2, 1'b0, 2'h0, '0);
        load(2'h3, 1'b0);
        chk(tag === 16'h00ab && flt === 1'b1, "tag above width");
        apb(1'b1, ppd_pkg::OFS_CFG, 32'h0000_1034);
    endtask

    task automatic t_rsvd();
        int pos[3] = '{400, 310, 262};
        for (int i = 0; i < 3; i++) begin
            ppd_entry_mem_i.store(3, 16'h0202, 40'h3, 1'b0, 2'h1, 512'h1 << pos[i]);
            load(2'h3, 1'b1);
            chk(flt === 1'b1, "reserved bit set");
            xlat(64'h0, 1'b0);
            svc(1'b0);
        end
        apb(1'b0, ppd_pkg::OFS_STATUS, '0);
        chk(rd[1:0] === 2'b11, "sticky fault and deny");
        apb(1'b1, ppd_pkg::OFS_STATUS, 32'h0000_0003);
        apb(1'b0, ppd_pkg::OFS_STATUS, '0);
        chk(rd[1:0] === 2'b00, "sticky flags cleared");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_fields();
        t_size();
        t_ctx_sup();
        t_tagw();
        t_rsvd();
        summarize();
    end
endmodule
